/* File: rtl/dpram_host.sv */
// One-port controller driving a dual-port memory with semaphore flags
`timescale 1ns/100ps
`include "dpram_host_cfg.svh"
module dpram_host
   import dpram_host_pkg::*;
(
   // Clock and reset
   input  wire logic                    clk_in,
   input  wire logic                    sys_rst_in,
   // Command port
   input  wire logic [3:0]              reg_addr_in,
   input  wire logic [31:0]             reg_wdata_in,
   input  wire logic                    reg_wr_in,
   input  wire logic                    reg_rd_in,
   output logic      [31:0]             reg_rdata_out,
   output logic                         irq_out,
   // Device port pins
   output logic                         chip_select_n_out,
   output logic                         flag_space_select_n_out,
   output logic                         write_n_out,
   output logic                         out_drive_n_out,
   output logic      [`ADDR_W-1:0]      addr_out,
   input  wire logic [`DATA_W-1:0]      data_in,
   output logic      [`DATA_W-1:0]      data_out,
   output logic                         data_oe_out,
   input  wire logic                    busy_n_in,
   input  wire logic                    int_n_in,
   // Cascade role strap for the device
   output logic                         master_sel_out
);

   // ----------------------------------------
   // Decoding shared by several sequencer states
   // ----------------------------------------
   // True for operations that write the device
   function automatic logic is_write(input op_t op);
      is_write = (op == OP_MEM_WR) || (op == OP_FLAG_WR);
   endfunction
   // True for semaphore-space operations
   function automatic logic is_flag(input op_t op);
      is_flag = (op == OP_FLAG_WR) || (op == OP_FLAG_RD);
   endfunction

   // ----------------------------------------
   // State
   // ----------------------------------------
   state_t                  state_q, state_d;        // Sequencer state
   op_t                     op_q, op_d;              // Current operation
   logic [`ADDR_W-1:0]      addr_q, addr_d;          // Target address
   logic [`DATA_W-1:0]      wdata_q, wdata_d;        // Write data
   logic [`DATA_W-1:0]      rdata_q, rdata_d;        // Last read word
   logic [`CNT_W-1:0]       cnt_q, cnt_d;            // Strobe timer
   logic [`IRQ_W-1:0]       istat_q, istat_d;        // Sticky events
   logic [`IRQ_W-1:0]       imask_q, imask_d;        // Event mask
   logic                    master_q, master_d;      // Cascade role
   logic                    oe_hold_q, oe_hold_d;    // Keep reads held
   logic                    busy_q, busy_d;          // Transfer in flight
   logic                    int_prev_q, int_prev_d;  // Interrupt pin history
   logic                    cs_n_q, cs_n_d;          // Pin registers
   logic                    fsel_n_q, fsel_n_d;
   logic                    we_n_q, we_n_d;
   logic                    oe_n_q, oe_n_d;
   logic                    doe_q, doe_d;
   logic [31:0]             rd_q, rd_d;              // Read data register
   logic                    irq_q, irq_d;
   logic [`IRQ_W-1:0]       ev;                      // Events this cycle

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   // Sequencer, pin drive and register file in one pass
   always_comb begin
      state_d    = state_q;
      op_d       = op_q;
      addr_d     = addr_q;
      wdata_d    = wdata_q;
      rdata_d    = rdata_q;
      cnt_d      = cnt_q;
      imask_d    = imask_q;
      master_d   = master_q;
      oe_hold_d  = oe_hold_q;
      busy_d     = busy_q;
      int_prev_d = !int_n_in;
      cs_n_d     = cs_n_q;
      fsel_n_d   = fsel_n_q;
      we_n_d     = we_n_q;
      oe_n_d     = oe_n_q;
      doe_d      = doe_q;
      rd_d       = '0;
      ev         = '0;
      // Falling edge of the device's interrupt flag
      ev[`IRQ_INT] = !int_n_in && !int_prev_q;
      // Register writes
      if (reg_wr_in) begin
         case (reg_addr_in)
            `REG_ADDR:     addr_d    = reg_wdata_in[`ADDR_W-1:0];
            `REG_WDATA:    wdata_d   = reg_wdata_in[`DATA_W-1:0];
            `REG_IRQ_MASK: imask_d   = reg_wdata_in[`IRQ_W-1:0];
            `REG_CTRL: begin
               master_d  = reg_wdata_in[`CTRL_MASTER];
               oe_hold_d = reg_wdata_in[`CTRL_OE_HOLD];
            end
            `REG_CMD: begin
               // Commands are dropped while a transfer runs
               if (!busy_q) begin
                  op_d   = op_t'(reg_wdata_in[`CMD_OP_W-1:0]);
                  busy_d = 1'b1;
                  state_d = ST_SETUP;
               end
            end
            default: ;
         endcase
      end
      // Sequencer
      case (state_q)
         ST_IDLE: begin
            // Standby: both selects high floats the device port
            cs_n_d  = 1'b1;
            fsel_n_d = 1'b1;
            we_n_d  = 1'b1;
            oe_n_d  = 1'b1;
            doe_d   = 1'b0;
         end
         ST_SETUP: begin
            // Only one select goes low, never both
            cs_n_d   = is_flag(op_q);
            fsel_n_d = !is_flag(op_q);
            we_n_d  = !is_write(op_q);
            oe_n_d  = is_write(op_q);
            doe_d   = is_write(op_q);
            cnt_d   = `CNT_W'(`ACCESS_CYC);
            state_d = ST_STROBE;
         end
         ST_STROBE: begin
            if (cnt_q > `CNT_W'(1)) begin
               cnt_d = cnt_q - `CNT_W'(1);
            end else if (!master_q && !busy_n_in && !is_flag(op_q)) begin
               // Lost arbitration: hold the cycle until busy clears
               ev[`IRQ_BUSY] = 1'b1;
               state_d = ST_WAITBUSY;
            end else begin
               if (!is_write(op_q)) begin
                  // Flag reads show the flag on every line; keep bit 0
                  rdata_d = is_flag(op_q) ? {{(`DATA_W-1){1'b0}}, data_in[0]} : data_in;
                  // Read of 0 after requesting means ownership
                  ev[`IRQ_OWNED] = is_flag(op_q) && !data_in[0];
               end
               we_n_d  = 1'b1;
               oe_n_d  = !(oe_hold_q && !is_write(op_q));
               doe_d   = 1'b0;
               state_d = ST_RECOVER;
            end
         end
         ST_WAITBUSY: begin
            // Slave device: busy pin sampled as an input
            if (busy_n_in) begin
               cnt_d   = `CNT_W'(`ACCESS_CYC);
               state_d = ST_STROBE;
            end
         end
         ST_RECOVER: begin
            cs_n_d  = 1'b1;
            fsel_n_d = 1'b1;
            if (!oe_hold_q) begin
               oe_n_d = 1'b1;
            end
            busy_d  = 1'b0;
            ev[`IRQ_DONE] = 1'b1;
            state_d = ST_IDLE;
         end
         default: state_d = ST_IDLE;
      endcase
      // Read mux; interrupt status read clears the sticky bits
      if (reg_rd_in) begin
         case (reg_addr_in)
            `REG_ADDR:     rd_d = 32'(addr_q);
            `REG_WDATA:    rd_d = 32'(wdata_q);
            `REG_RDATA:    rd_d = 32'(rdata_q);
            `REG_STATUS:   rd_d = 32'({!int_n_in, !busy_n_in, busy_q});
            `REG_IRQ_STAT: rd_d = 32'(istat_q);
            `REG_IRQ_MASK: rd_d = 32'(imask_q);
            `REG_CTRL:     rd_d = 32'({oe_hold_q, master_q});
            default:       rd_d = '0;
         endcase
      end
      // Set wins over the read clear
      istat_d = ((reg_rd_in && reg_addr_in == `REG_IRQ_STAT) ? '0 : istat_q) | ev;
      irq_d   = |(istat_d & imask_d);
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   // Synchronous reset to idle, device deselected
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         state_q    <= ST_IDLE;
         op_q       <= OP_MEM_RD;
         addr_q     <= '0;
         wdata_q    <= '0;
         rdata_q    <= '0;
         cnt_q      <= '0;
         istat_q    <= '0;
         imask_q    <= '0;
         master_q   <= 1'b1;
         oe_hold_q  <= 1'b0;
         busy_q     <= 1'b0;
         int_prev_q <= 1'b0;
         cs_n_q     <= 1'b1;
         fsel_n_q   <= 1'b1;
         we_n_q     <= 1'b1;
         oe_n_q     <= 1'b1;
         doe_q      <= 1'b0;
         rd_q       <= '0;
         irq_q      <= 1'b0;
      end else begin
         state_q    <= state_d;
         op_q       <= op_d;
         addr_q     <= addr_d;
         wdata_q    <= wdata_d;
         rdata_q    <= rdata_d;
         cnt_q      <= cnt_d;
         istat_q    <= istat_d;
         imask_q    <= imask_d;
         master_q   <= master_d;
         oe_hold_q  <= oe_hold_d;
         busy_q     <= busy_d;
         int_prev_q <= int_prev_d;
         cs_n_q     <= cs_n_d;
         fsel_n_q   <= fsel_n_d;
         we_n_q     <= we_n_d;
         oe_n_q     <= oe_n_d;
         doe_q      <= doe_d;
         rd_q       <= rd_d;
         irq_q      <= irq_d;
      end
   end

   // ----------------------------------------
   // Outputs, all from flip-flops
   // ----------------------------------------
   assign chip_select_n_out       = cs_n_q;
   assign flag_space_select_n_out = fsel_n_q;
   assign write_n_out             = we_n_q;
   assign out_drive_n_out         = oe_n_q;
   // Address bits 2:0 pick the flag in flag space
   assign addr_out                = addr_q;
   // Flag writes carry the value in bit 0 only
   assign data_out                = wdata_q;
   assign data_oe_out             = doe_q;
   assign master_sel_out          = master_q;
   assign reg_rdata_out           = rd_q;
   assign irq_out                 = irq_q;
endmodule

/* File: pkg/dpram_host_cfg.svh */
// Constants for the dual-port memory port controller
`ifndef DPRAM_HOST_CFG_SVH
`define DPRAM_HOST_CFG_SVH
// ----------------------------------------
// Register offsets (word index on the command port)
// ----------------------------------------
`define REG_ADDR       4'h0
`define REG_WDATA      4'h1
`define REG_CMD        4'h2
`define REG_RDATA      4'h3
`define REG_STATUS     4'h4
`define REG_IRQ_STAT   4'h5
`define REG_IRQ_MASK   4'h6
`define REG_CTRL       4'h7
// ----------------------------------------
// Field positions and widths
// ----------------------------------------
`define ADDR_W         13
`define DATA_W         9
`define FLAG_IDX_W     3
`define CMD_OP_W       2
`define IRQ_W          4
`define IRQ_DONE       0
`define IRQ_BUSY       1
`define IRQ_INT        2
`define IRQ_OWNED      3
`define CTRL_MASTER    0
`define CTRL_OE_HOLD   1
// ----------------------------------------
// Timing: strobe width for a 20 ns device at 10 ns clock
// ----------------------------------------
`define ACCESS_NS      20
`define CLK_NS         10
`define ACCESS_CYC     ((`ACCESS_NS + `CLK_NS - 1) / `CLK_NS)
`define CNT_W          4
`endif

/* File: pkg/dpram_host_pkg.sv */
// Types for the dual-port memory port controller
package dpram_host_pkg;
   // Operation codes written to the command register
   typedef enum logic [1:0] {
      OP_MEM_WR,
      OP_MEM_RD,
      OP_FLAG_WR,
      OP_FLAG_RD
   } op_t;
   // Sequencer states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SETUP,
      ST_STROBE,
      ST_WAITBUSY,
      ST_RECOVER
   } state_t;
endpackage

/* File: verif/dpram_host_sva.sv */
// Pin-level checks on the memory port controller
`timescale 1ns/100ps
`include "dpram_host_cfg.svh"
module dpram_host_sva (
   // Clock and reset
   input wire logic               clk_in,
   input wire logic               sys_rst_in,
   // Device pins
   input wire logic               chip_select_n_out,
   input wire logic               flag_space_select_n_out,
   input wire logic               write_n_out,
   input wire logic               out_drive_n_out,
   input wire logic [`ADDR_W-1:0] addr_out,
   input wire logic               data_oe_out,
   input wire logic               master_sel_out
);
   // ----------------------------
   // Pin discipline
   // ----------------------------
   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   sel_excl_a: assert property (chip_select_n_out || flag_space_select_n_out)
      else $error("both selects low");
   wr_drive_a: assert property (!write_n_out |-> data_oe_out && out_drive_n_out)
      else $error("write strobe without data drive");
   no_fight_a: assert property (!out_drive_n_out |-> !data_oe_out)
      else $error("device and controller drive together");
   idle_float_a: assert property (chip_select_n_out && flag_space_select_n_out |-> !data_oe_out)
      else $error("data driven while deselected");
   // Busy wait may stretch a slave strobe, so only master runs are timed
   strobe_len_a: assert property ($fell(write_n_out) && master_sel_out |->
      !write_n_out ##1 !write_n_out ##1 write_n_out)
      else $error("write strobe not two cycles");
   addr_hold_a: assert property (!chip_select_n_out && $past(!chip_select_n_out) |-> $stable(addr_out))
      else $error("address moved in memory access");
   fidx_hold_a: assert property ($fell(flag_space_select_n_out) |=> $stable(addr_out) [*2])
      else $error("flag index moved in flag access");
   flag_len_a: assert property ($fell(flag_space_select_n_out) |-> ##[1:4] flag_space_select_n_out)
      else $error("flag access too long");
   mem_wr_c: cover property (!chip_select_n_out && !write_n_out);
   mem_rd_c: cover property (!chip_select_n_out && !out_drive_n_out);
   flag_rd_c: cover property (!flag_space_select_n_out && !out_drive_n_out);
   // Flag write strobe, the path that takes and frees a flag
   flag_wr_c: cover property (!flag_space_select_n_out && !write_n_out);
endmodule
bind dpram_host dpram_host_sva sva (.clk_in, .sys_rst_in, .chip_select_n_out, .flag_space_select_n_out,
   .write_n_out, .out_drive_n_out, .addr_out, .data_oe_out, .master_sel_out);

/* File: verif/dpram_dev_model.sv */
// Behavioural model of one port of the shared memory device
`timescale 1ns/100ps
module dpram_dev_model (
   // Port pins from the controller
   input  wire logic        cs_n_in,
   input  wire logic        fsel_n_in,
   input  wire logic        we_n_in,
   input  wire logic        oe_n_in,
   input  wire logic [12:0] addr_in,
   input  wire logic [8:0]  data_in,
   // Data driven back
   output logic      [8:0]  data_out
);
   // ----------------------------
   // Storage, no clock anywhere
   // ----------------------------
   logic [8:0] mem_q [0:8191];    // Word store
   logic [7:0] flag_q  = 8'hFF;   // Flags, all free at power up
   logic [8:0] stale_q = 9'h000;  // Value seen on a released bus
   logic [8:0] rd_w;              // Selected word or flag
   logic       drive_w;           // Device owns the data lines
   // Writes land on the rising write strobe
   always @(posedge we_n_in) begin
      if (!cs_n_in && fsel_n_in) mem_q[addr_in] <= data_in;
      if (cs_n_in && !fsel_n_in) flag_q[addr_in[2:0]] <= data_in[0];
   end
   // Plain lookup, so two readers never disturb each other
   assign rd_w = fsel_n_in ? mem_q[addr_in] : {9{flag_q[addr_in[2:0]]}};
   assign drive_w = !oe_n_in && we_n_in && (cs_n_in != fsel_n_in);
   // Released lines flip, so a stale sample cannot pass as data
   always @(posedge oe_n_in) stale_q <= ~rd_w;
   assign data_out = drive_w ? rd_w : stale_q;
endmodule

/* File: verif/tb_top.sv */
// Self-checking bench for the memory port controller
`timescale 1ns/100ps
`include "dpram_host_cfg.svh"
module tb_top
   import dpram_host_pkg::*;
();
   // ----------------------------
   // Signals and case table
   // ----------------------------
   typedef struct {op_t op; logic [12:0] a; logic [8:0] d; logic [8:0] m;} row_t; // Data or expect, mask
   logic        clk_in = 1'h0, sys_rst_in = 1'h1, reg_wr_in = 1'h0, reg_rd_in = 1'h0;
   logic [3:0]  reg_addr_in = 4'h0;
   logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out, v;
   logic        irq_out, cs_n, fs_n, we_n, oe_n, data_oe, master_sel;
   logic        busy_n_in = 1'h1, int_n_in = 1'h1; // Push-pull flags of the far side
   logic [12:0] addr;
   logic [8:0]  dout, dev_q, data_in;
   int          n_errors = 0, samples_checked = 0;
   row_t rows [11] = '{'{OP_MEM_WR, 13'h1FFF, 9'h1A5, 9'h000}, '{OP_MEM_RD, 13'h1FFF, 9'h1A5, 9'h1FF},
      '{OP_MEM_WR, 13'h0000, 9'h05A, 9'h000}, '{OP_MEM_RD, 13'h0000, 9'h05A, 9'h1FF},
      '{OP_MEM_RD, 13'h1FFF, 9'h1A5, 9'h1FF}, '{OP_FLAG_RD, 13'h0005, 9'h001, 9'h1FF},
      '{OP_FLAG_WR, 13'h1FFD, 9'h1FE, 9'h000}, '{OP_FLAG_RD, 13'h0005, 9'h000, 9'h1FF},
      '{OP_FLAG_RD, 13'h0004, 9'h001, 9'h1FF}, '{OP_FLAG_WR, 13'h0005, 9'h001, 9'h000},
      '{OP_FLAG_RD, 13'h0005, 9'h001, 9'h1FF}};
   always #5 clk_in = ~clk_in;
   assign data_in = data_oe ? dout : dev_q; // Resolve the shared data lines
   dpram_host uut (.clk_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
      .reg_rdata_out, .irq_out, .chip_select_n_out(cs_n), .flag_space_select_n_out(fs_n),
      .write_n_out(we_n), .out_drive_n_out(oe_n), .addr_out(addr), .data_in, .data_out(dout),
      .data_oe_out(data_oe), .busy_n_in, .int_n_in, .master_sel_out(master_sel));
   dpram_dev_model dev (.cs_n_in(cs_n), .fsel_n_in(fs_n), .we_n_in(we_n), .oe_n_in(oe_n),
      .addr_in(addr), .data_in(dout), .data_out(dev_q));
   // ----------------------------
   // Bus tasks and compare
   // ----------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'h1;
      @(posedge clk_in);
      reg_wr_in <= 1'h0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'h1;
      @(posedge clk_in);
      reg_rd_in <= 1'h0;
      #1 d = reg_rdata_out;
   endtask
   task automatic go(input op_t op, input logic [12:0] a, input logic [8:0] d);
      wr(`REG_ADDR, {19'h0, a});
      wr(`REG_WDATA, {23'h0, d});
      wr(`REG_CMD, {30'h0, op});
   endtask
   // Bounded poll of the busy bit; a hang shows as a mismatch
   task automatic fin;
      v = 32'h1;
      repeat (30) if (v[0] !== 1'h0) rd(`REG_STATUS, v);
      chk(v[0], 32'h0);
   endtask
   // One device access, then compare the word that it returned
   task automatic acc(input op_t op, input logic [12:0] a, input logic [31:0] e);
      go(op, a, 9'h000);
      fin;
      rd(`REG_RDATA, v);
      chk(v, e);
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ----------------------------
   // Sequence
   // ----------------------------
   initial begin
      #100000;
      n_errors++;
      test_done;
   end
   initial begin
      repeat (6) @(posedge clk_in);
      sys_rst_in <= 1'h0;
      #1 chk({cs_n, fs_n, we_n, oe_n, data_oe, irq_out, master_sel}, 32'h79);
      chk(reg_rdata_out, 32'h0);
      foreach (rows[i]) begin
         go(rows[i].op, rows[i].a, rows[i].d);
         fin;
         if (rows[i].op[0]) begin
            rd(`REG_RDATA, v);
            chk(v & rows[i].m, rows[i].d & rows[i].m);
         end
      end
      // Done interrupt raised, then cleared by reading
      rd(`REG_IRQ_STAT, v);
      wr(`REG_IRQ_MASK, 32'h1);
      go(OP_MEM_RD, 13'h0000, 9'h000);
      fin;
      chk(irq_out, 32'h1);
      rd(`REG_IRQ_STAT, v);
      chk(v, 32'h1);
      repeat (2) @(posedge clk_in);
      chk(irq_out, 32'h0);
      // Masked: flag taken, no interrupt line
      wr(`REG_IRQ_MASK, 32'h0);
      go(OP_FLAG_WR, 13'h0002, 9'h000);
      fin;
      go(OP_FLAG_RD, 13'h1FFA, 9'h000);
      fin;
      chk(irq_out, 32'h0);
      rd(`REG_IRQ_STAT, v);
      chk(v, 32'h9);
      // Interrupt pin falling edge
      @(posedge clk_in);
      int_n_in <= 1'h0;
      repeat (3) @(posedge clk_in);
      int_n_in <= 1'h1;
      rd(`REG_IRQ_STAT, v);
      chk(v & 32'h4, 32'h4);
      // Slave role: busy held low stalls a memory write
      wr(`REG_CTRL, 32'h0);
      busy_n_in <= 1'h0;
      #1 chk(master_sel, 32'h0);
      go(OP_MEM_WR, 13'h0010, 9'h0AA);
      repeat (6) @(posedge clk_in);
      // Still waiting: transfer busy, busy pin seen low
      rd(`REG_STATUS, v);
      chk(v, 32'h3);
      @(posedge clk_in);
      busy_n_in <= 1'h1;
      fin;
      rd(`REG_IRQ_STAT, v);
      chk(v & 32'h2, 32'h2);
      wr(`REG_CTRL, 32'h1);
      #1 chk(master_sel, 32'h1);
      // The stalled write must have landed once busy cleared
      acc(OP_MEM_RD, 13'h0010, 32'h0AA);
      // A command written while a transfer runs is dropped
      go(OP_MEM_WR, 13'h0020, 9'h0AA);
      wr(`REG_CMD, {30'h0, OP_FLAG_WR});
      fin;
      acc(OP_FLAG_RD, 13'h0020, 32'h1);
      acc(OP_MEM_RD, 13'h0020, 32'h0AA);
      // Reset in mid-transfer: pins back to standby, block usable again
      go(OP_MEM_RD, 13'h1FFF, 9'h000);
      @(posedge clk_in);
      sys_rst_in <= 1'h1;
      repeat (2) @(posedge clk_in);
      sys_rst_in <= 1'h0;
      #1 chk({cs_n, fs_n, we_n, oe_n, data_oe, irq_out, master_sel}, 32'h79);
      rd(`REG_STATUS, v);
      chk(v, 32'h0);
      acc(OP_MEM_RD, 13'h1FFF, 32'h1A5);
      rd(4'h8, v);
      chk(v, 32'h0);
      test_done;
   end
endmodule
